//--- hw/ppp_host.sv
`timescale 1ns/100ps
`default_nettype none
module ppp_host
    import ppp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TRIES = MAX_TRIES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic req_valid,
    input wire ppp_req_s req,
    output logic req_ready,
    output logic done_pulse,
    output logic fail,
    output logic [PAGE_BYTES*DATA_W-1:0] rd_data,
    output logic [TRY_W-1:0] tries_used,
    output ppp_ctl_s ctl,
    output logic [ADDR_W-1:0] prog_addr_lines,
    output logic [DATA_W-1:0] prog_data_lines_o,
    output logic prog_data_lines_oe,
    input wire logic [DATA_W-1:0] prog_data_lines_i
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ENTER = 4'h1,
        ST_LATCH = 4'h2,
        ST_PULSE = 4'h3,
        ST_RECOV = 4'h4,
        ST_VERIFY = 4'h5,
        ST_SAMPLE = 4'h6,
        ST_DONE = 4'h7
    } ppp_st_e;

    ppp_st_e st_r;
    ppp_req_s req_r;
    logic [1:0] idx_r;
    logic [TRY_W-1:0] try_r;
    logic bad_r;
    logic tmr_load;
    logic [15:0] tmr_count;
    logic tmr_done;
    logic [DATA_W-1:0] din_meta_r, din_r;
    logic [1:0] last_idx;

    ppp_timer #(.W(16)) u_timer (
        .clock(clock),
        .reset(reset),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Pin data arrives asynchronously to our clock
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            din_meta_r <= 8'h00;
            din_r <= 8'h00;
        end else begin
            din_meta_r <= prog_data_lines_i;
            din_r <= din_meta_r;
        end
    end

    assign last_idx = (req_r.op == PPP_OP_PAGE) ? 2'h3 : 2'h0;

    always_comb begin
        tmr_load = 1'b0;
        tmr_count = 16'(SETUP_CYC);
        unique case (st_r)
            ST_IDLE: tmr_load = req_valid;
            // Pulse end reloads the setup count, which paces the recovery gap
            ST_ENTER, ST_LATCH, ST_PULSE, ST_RECOV, ST_VERIFY: tmr_load = tmr_done;
            // Reload every sample so a retried byte pulse gets its full width
            ST_SAMPLE: tmr_load = 1'b1;
            default: tmr_load = 1'b0;
        endcase
        // Next step after latching the last byte is the long pulse
        if (st_r == ST_LATCH && tmr_done && req_r.op != PPP_OP_READ && idx_r == last_idx) begin
            tmr_count = 16'(PULSE_CYCLES);
        end
        if (st_r == ST_ENTER && tmr_done && req_r.op == PPP_OP_BYTE) begin
            tmr_count = 16'(PULSE_CYCLES);
        end
        if (st_r == ST_SAMPLE && req_r.op == PPP_OP_BYTE) begin
            tmr_count = 16'(PULSE_CYCLES);
        end
    end

    // Sequencer
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_r <= ST_IDLE;
            req_r <= '0;
            idx_r <= 2'h0;
            try_r <= '0;
            bad_r <= 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: if (req_valid) begin
                    req_r <= req;
                    idx_r <= 2'h0;
                    try_r <= '0;
                    bad_r <= 1'b0;
                    st_r <= ST_ENTER;
                end
                ST_ENTER: if (tmr_done) begin
                    if (req_r.op == PPP_OP_READ) st_r <= ST_VERIFY;
                    else if (req_r.op == PPP_OP_BYTE) st_r <= ST_PULSE;
                    else st_r <= ST_LATCH;
                end
                ST_LATCH: if (tmr_done) begin
                    if (idx_r == last_idx) begin
                        idx_r <= 2'h0;
                        st_r <= ST_PULSE;
                    end else begin
                        idx_r <= idx_r + 2'h1;
                    end
                end
                ST_PULSE: if (tmr_done) begin
                    try_r <= try_r + 1'b1;
                    st_r <= ST_RECOV;
                end
                ST_RECOV: if (tmr_done) st_r <= ST_VERIFY;
                ST_VERIFY: if (tmr_done) st_r <= ST_SAMPLE;
                ST_SAMPLE: begin
                    // Compare against the byte in flight; reads just capture
                    if (req_r.op != PPP_OP_READ && din_r != req_r.data[idx_r*DATA_W +: DATA_W]) begin
                        if (try_r >= TRY_W'(TRIES)) begin
                            bad_r <= 1'b1;
                            st_r <= ST_DONE;
                        end else begin
                            idx_r <= 2'h0;
                            st_r <= (req_r.op == PPP_OP_PAGE) ? ST_LATCH : ST_PULSE;
                        end
                    end else if (idx_r == last_idx) begin
                        st_r <= ST_DONE;
                    end else begin
                        idx_r <= idx_r + 2'h1;
                        st_r <= ST_VERIFY;
                    end
                end
                ST_DONE: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Pins: supply and reset held for the whole job, strobes per state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctl <= '{ce_n: 1'b1, oe_n: 1'b1, pgm_n: 1'b1, reset_n: 1'b1,
                     vpp_on: 1'b0, vpp_high: 1'b0};
            prog_addr_lines <= '0;
            prog_data_lines_o <= 8'h00;
            prog_data_lines_oe <= 1'b0;
        end else begin
            ctl.reset_n <= (st_r == ST_IDLE) && !req_valid;
            ctl.vpp_on <= (st_r != ST_IDLE) || req_valid;
            ctl.vpp_high <= (st_r == ST_IDLE) ? (req_valid && req.op != PPP_OP_READ)
                                              : (req_r.op != PPP_OP_READ);
            // Address wraps at the 15-bit line width (32 Kbyte); callers stay at or below ADDR_LAST
            prog_addr_lines <= req_r.addr + ADDR_W'(idx_r);
            prog_data_lines_o <= req_r.data[idx_r*DATA_W +: DATA_W];
            unique case (st_r)
                ST_LATCH: begin
                    ctl.ce_n <= 1'b1;
                    ctl.oe_n <= 1'b0;
                    ctl.pgm_n <= 1'b1;
                    prog_data_lines_oe <= 1'b1;
                end
                ST_PULSE: begin
                    ctl.ce_n <= (req_r.op == PPP_OP_PAGE);
                    ctl.oe_n <= 1'b1;
                    ctl.pgm_n <= tmr_done;
                    prog_data_lines_oe <= 1'b1;
                end
                ST_VERIFY, ST_SAMPLE: begin
                    ctl.ce_n <= 1'b0;
                    ctl.oe_n <= 1'b0;
                    ctl.pgm_n <= 1'b1;
                    prog_data_lines_oe <= 1'b0;
                end
                default: begin
                    ctl.ce_n <= 1'b1;
                    ctl.oe_n <= 1'b1;
                    ctl.pgm_n <= 1'b1;
                    prog_data_lines_oe <= (st_r == ST_ENTER) && (req_r.op == PPP_OP_BYTE);
                end
            endcase
        end
    end

    // Results to the user side
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            req_ready <= 1'b0;
            done_pulse <= 1'b0;
            fail <= 1'b0;
            rd_data <= '0;
            tries_used <= '0;
        end else begin
            req_ready <= (st_r == ST_IDLE) && !req_valid || (st_r == ST_DONE);
            done_pulse <= (st_r == ST_DONE);
            if (st_r == ST_DONE) begin
                fail <= bad_r;
                tries_used <= try_r;
            end
            if (st_r == ST_SAMPLE) rd_data[idx_r*DATA_W +: DATA_W] <= din_r;
        end
    end
endmodule
`default_nettype wire

//--- hw/ppp_pkg.sv
package ppp_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic [14:0] ADDR_LAST = 15'h5FFF;
    localparam int PAGE_BYTES = 4;
    localparam int CLK_MHZ = 50;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
    localparam int SETUP_CYC = 4;
    localparam int MAX_TRIES = 10;
    localparam int TRY_W = 4;

    typedef enum logic [1:0] {
        PPP_OP_READ = 2'h0,
        PPP_OP_BYTE = 2'h1,
        PPP_OP_PAGE = 2'h2
    } ppp_op_e;

    typedef struct packed {
        ppp_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_BYTES*DATA_W-1:0] data;
    } ppp_req_s;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic pgm_n;
        logic reset_n;
        logic vpp_on;
        logic vpp_high;
    } ppp_ctl_s;
endpackage

//--- hw/ppp_timer.sv
`timescale 1ns/100ps
`default_nettype none
module ppp_timer
    import ppp_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic done
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Done reads the count only, so a load driven from done forms no loop
    assign done = (cnt_r == '0);
endmodule
`default_nettype wire

//--- sim/ppp_prom_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppp_prom_model
    import ppp_pkg::*;
(
    input wire logic clock,
    input wire ppp_ctl_s ctl,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] din,
    output logic [DATA_W-1:0] dout,
    output logic drive
);
    logic [DATA_W-1:0] mem [0:24575];
    logic [DATA_W-1:0] page [0:3];
    logic mode;
    assign mode = ctl.vpp_on && !ctl.reset_n;
    assign drive = mode && !ctl.ce_n && !ctl.oe_n;
    assign dout = mem[addr];
    initial begin
        for (int i = 0; i < 24576; i++) begin
            mem[i] = 8'hFF;
        end
    end
    always @(posedge clock) begin
        if (mode && ctl.ce_n && ctl.pgm_n && !ctl.oe_n) begin
            page[addr[1:0]] <= din;
        end
    end
    // Programming only clears bits, so rewriting a one over a zero fails verify
    always @(negedge ctl.pgm_n) begin
        if (mode && ctl.oe_n && ctl.ce_n) begin
            for (int i = 0; i < 4; i++) begin
                mem[{addr[14:2], 2'(i)}] &= page[i];
            end
        end else if (mode && ctl.oe_n) begin
            mem[addr] &= din;
        end
    end
endmodule
`default_nettype wire

//--- sim/ppp_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ppp_host_chk
    import ppp_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int TRIES = MAX_TRIES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic done_pulse,
    input wire logic fail,
    input wire logic [TRY_W-1:0] tries_used,
    input wire ppp_ctl_s ctl,
    input wire logic [ADDR_W-1:0] prog_addr_lines,
    input wire logic [DATA_W-1:0] prog_data_lines_o,
    input wire logic prog_data_lines_oe
);
    int low_cnt;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            low_cnt <= 0;
        end else begin
            low_cnt <= ctl.pgm_n ? 0 : low_cnt + 1;
        end
    end
    sequence s_pulse_on;
        $fell(ctl.pgm_n);
    endsequence
    sequence s_pulse_off;
        $rose(ctl.pgm_n);
    endsequence
    AST_MODE_HELD:
        assert property (!ctl.pgm_n |-> ctl.vpp_on && ctl.vpp_high && !ctl.reset_n)
        else $error("pulse outside programming mode");
    AST_ADDR_LEGAL:
        assert property (!ctl.pgm_n |-> prog_addr_lines <= ADDR_LAST)
        else $error("pulse beyond last address");
    AST_PULSE_LEN:
        assert property (s_pulse_off |-> low_cnt == PULSE_CYCLES)
        else $error("program pulse width wrong");
    AST_PULSE_OE:
        assert property (s_pulse_on |-> ctl.oe_n)
        else $error("read strobe low at pulse");
    AST_PULSE_STEADY:
        assert property (!ctl.pgm_n && !$past(ctl.pgm_n) |->
            $stable(ctl.ce_n) && $stable(prog_addr_lines) && $stable(prog_data_lines_o))
        else $error("lines moved during pulse");
    AST_BYTE_DATA:
        assert property (s_pulse_on ##0 !ctl.ce_n |-> prog_data_lines_oe)
        else $error("byte pulse without data");
    AST_NO_FIGHT:
        assert property (!ctl.ce_n && !ctl.oe_n |-> !prog_data_lines_oe)
        else $error("host drives during read");
    AST_LATCH_DRIVE:
        assert property (ctl.vpp_on && ctl.ce_n && ctl.pgm_n && !ctl.oe_n |-> prog_data_lines_oe)
        else $error("latch without data");
    AST_TRIES_CAP:
        assert property (done_pulse |-> tries_used <= TRIES && (!fail || tries_used == TRIES))
        else $error("retry count wrong");
endmodule
bind ppp_host ppp_host_chk #(.PULSE_CYCLES(PULSE_CYCLES), .TRIES(TRIES)) u_chk (
    .clock(clock), .reset(reset), .done_pulse(done_pulse), .fail(fail),
    .tries_used(tries_used), .ctl(ctl), .prog_addr_lines(prog_addr_lines),
    .prog_data_lines_o(prog_data_lines_o), .prog_data_lines_oe(prog_data_lines_oe));
`default_nettype wire

//--- sim/ppp_host_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ppp_host_bench;
    import ppp_pkg::*;
    typedef struct packed {
        logic fail;
        logic [31:0] data;
        logic [31:0] mask;
        logic [TRY_W-1:0] tries;
    } ppp_note_s;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    ppp_req_s req = '0;
    logic req_ready, done_pulse, fail, host_oe, dev_drive;
    logic [31:0] rd_data;
    logic [TRY_W-1:0] tries_used;
    ppp_ctl_s ctl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] host_do, dev_do, bus;
    logic [DATA_W-1:0] last = 8'h00;
    logic [31:0] seed = 32'h8785D583;
    logic [7:0] shadow [0:24575];
    ppp_note_s notes [$];
    ppp_note_s got;
    int bad_count = 0;
    int check_count = 0;
    always #10 clock = ~clock;
    // No pull on the data lines: a floating bus shows the inverse of its last level
    assign bus = host_oe ? host_do : dev_drive ? dev_do : ~last;
    always @(posedge clock) last <= bus;
    ppp_host #(.PULSE_CYCLES(20)) u_dut (.clock(clock), .reset(reset), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .done_pulse(done_pulse), .fail(fail),
        .rd_data(rd_data), .tries_used(tries_used), .ctl(ctl), .prog_addr_lines(addr),
        .prog_data_lines_o(host_do), .prog_data_lines_oe(host_oe), .prog_data_lines_i(bus));
    ppp_prom_model u_prom (.clock(clock), .ctl(ctl), .addr(addr), .din(bus),
        .dout(dev_do), .drive(dev_drive));
    function automatic logic [31:0] lfsr();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    task automatic results();
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_fail(input logic g, input logic e);
        cmp({31'h0, g}, {31'h0, e});
    endtask
    task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e);
    endtask
    task automatic cmp_tries(input logic [TRY_W-1:0] g, input logic [TRY_W-1:0] e);
        cmp({28'h0, g}, {28'h0, e});
    endtask
    task automatic job(input ppp_op_e op, input logic [14:0] a, input logic [31:0] d);
        ppp_note_s n;
        logic [7:0] nv;
        int k;
        n = '{fail: 1'b0, data: 32'h0, mask: (op == PPP_OP_PAGE) ? 32'hFFFFFFFF : 32'hFF,
            tries: (op == PPP_OP_READ) ? 4'h0 : 4'h1};
        for (int i = 0; i < ((op == PPP_OP_PAGE) ? 4 : 1); i++) begin
            nv = shadow[a + i];
            if (op != PPP_OP_READ) begin
                nv = nv & d[8*i+:8];
                n.fail |= (nv != d[8*i+:8]);
                shadow[a + i] = nv;
            end
            n.data[8*i+:8] = nv;
        end
        if (n.fail) begin
            n.mask = 32'h0;
            n.tries = TRY_W'(MAX_TRIES);
        end
        for (k = 0; k < 2000 && req_ready !== 1'b1; k++) begin
            @(posedge clock);
            #2;
        end
        if (k == 2000) begin
            cmp(32'h0, 32'h1);
            results();
        end
        req = '{op: op, addr: a, data: d};
        req_valid = 1'b1;
        notes.push_back(n);
        @(posedge clock);
        #2;
        // Busy requests must be ignored, else an extra completion shows up
        req = '{op: PPP_OP_READ, addr: 15'h0000, data: 32'h0};
        repeat (3) @(posedge clock);
        #2;
        req_valid = 1'b0;
    endtask
    always @(posedge clock) begin
        if (done_pulse === 1'b1) begin
            if (notes.size() == 0) begin
                cmp(32'h1, 32'h0);
            end else begin
                got = notes.pop_front();
                cmp_fail(fail, got.fail);
                cmp_data(rd_data & got.mask, got.data & got.mask);
                if (got.tries != 4'h0) begin
                    cmp_tries(tries_used, got.tries);
                end
            end
        end
    end
    initial begin
        logic [31:0] r;
        logic [14:0] a;
        // Blank array reads all ones until programmed
        for (int i = 0; i < 24576; i++) begin
            shadow[i] = 8'hFF;
        end
        repeat (20) @(posedge clock);
        #2;
        reset = 1'b0;
        job(PPP_OP_READ, 15'h0000, 32'h0);
        job(PPP_OP_BYTE, ADDR_LAST, lfsr());
        job(PPP_OP_READ, ADDR_LAST, 32'h0);
        job(PPP_OP_PAGE, 15'h0100, lfsr());
        job(PPP_OP_READ, 15'h0102, 32'h0);
        job(PPP_OP_BYTE, 15'h0010, 32'h0);
        job(PPP_OP_BYTE, 15'h0010, 32'hA5);
        job(PPP_OP_PAGE, 15'h0100, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) begin
            r = lfsr();
            a = 15'(r[31:8] % 24576) & 15'h7FFC;
            job(ppp_op_e'(r[1:0] % 3), a, lfsr());
        end
        for (int k = 0; k < 2000 && notes.size() > 0; k++) begin
            @(posedge clock);
        end
        cmp(notes.size(), 32'h0);
        results();
    end
endmodule
`default_nettype wire
